//--- lsdfc_pkg.sv
package lsdfc_pkg;

   // channel and data widths
   localparam int NCH        = 6;
   localparam int NCH_W      = 3;
   localparam int DUTY_W     = 8;
   localparam int DUTY_SHIFT = 8;
   localparam int PER_W      = 17;
   localparam int MEAS_W     = 18;
   localparam int RES_W      = 21;

   // dimming frequency is a constant over the mode-pin resistance
   localparam longint CLK_HZ          = 10_000_000;
   localparam longint DIM_FREQ_OHM_HZ = 181_800_000;

   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int CHECK_TIME_NS = 100_000;
   localparam int CHECK_CYC     = (CHECK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CHK_W         = $clog2(CHECK_CYC + 1);
   localparam int OC_PERSIST_SW = 32;

   typedef enum logic [1:0] {
      ST_OFF   = 2'b00,
      ST_CHECK = 2'b01,
      ST_RUN   = 2'b10,
      ST_LATCH = 2'b11
   } lsdfc_state_e;

   // analog comparators and boost timing seen by the control logic
   typedef struct packed {
      logic inductor_oc;
      logic cycle_start;
      logic out_short;
      logic over_temp;
      logic clamp_over;
   } lsdfc_sense_s;

   // controls handed to the boost stage
   typedef struct packed {
      logic enable;
      logic switch_allow;
      logic clamp;
   } lsdfc_boost_s;

   function automatic logic [NCH_W-1:0] lsdfc_popcount(input logic [NCH-1:0] v);
      logic [NCH_W-1:0] c;
      c = '0;
      for (int i = 0; i < NCH; i++) begin
         c = c + NCH_W'(v[i]);
      end
      return c;
   endfunction

   function automatic logic [PER_W-1:0] lsdfc_period_cycles(input logic [RES_W-1:0] res);
      longint p;
      p = (longint'(res) * CLK_HZ) / DIM_FREQ_OHM_HZ;
      if (p < 1) begin
         p = 1;
      end
      if (p > (longint'(1) << PER_W) - 1) begin
         p = (longint'(1) << PER_W) - 1;
      end
      return PER_W'(p);
   endfunction

endpackage

//--- lsdfc_duty_meter.sv
`timescale 1ns/10ps
`default_nettype none
module lsdfc_duty_meter import lsdfc_pkg::*; #(
   parameter int W = MEAS_W
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // control
   input  wire logic              en,
   input  wire logic              pwm,
   // result
   output logic [DUTY_W-1:0]      duty,
   output logic                   valid
);

   typedef struct packed {
      logic              prev;
      logic              armed;
      logic              valid;
      logic [W-1:0]      hi;
      logic [W-1:0]      per;
      logic [DUTY_W-1:0] duty;
   } lsdfc_meter_s;

   lsdfc_meter_s s_r;
   lsdfc_meter_s s_nxt;

   function automatic logic [DUTY_W-1:0] raw_duty(input logic [W-1:0] hi,
                                                  input logic [W-1:0] per);
      logic [W+DUTY_SHIFT-1:0] q;
      q = '0;
      if (per != '0) begin
         q = {hi, {DUTY_SHIFT{1'b0}}} / {{DUTY_SHIFT{1'b0}}, per};
      end
      if (q > (W+DUTY_SHIFT)'({DUTY_W{1'b1}})) begin
         return {DUTY_W{1'b1}};
      end
      return q[DUTY_W-1:0];
   endfunction

   // one lsb dead band: rising passes at once, falling needs two lsb
   function automatic logic [DUTY_W-1:0] hyst(input logic [DUTY_W-1:0] stored,
                                              input logic [DUTY_W-1:0] raw);
      if (raw > stored) begin
         return raw;
      end
      if ({1'b0, raw} + 9'h001 < {1'b0, stored}) begin
         return raw;
      end
      return stored;
   endfunction

   always_comb begin
      s_nxt = s_r;
      if (!en) begin
         s_nxt = '0;
      end else begin
         s_nxt.prev = pwm;
         if (pwm && !s_r.prev) begin
            if (s_r.armed) begin
               s_nxt.duty  = s_r.valid ? hyst(s_r.duty, raw_duty(s_r.hi, s_r.per))
                                       : raw_duty(s_r.hi, s_r.per);
               s_nxt.valid = 1'b1;
            end
            s_nxt.armed = 1'b1;
            s_nxt.hi    = W'(1);
            s_nxt.per   = W'(1);
         end else begin
            if (s_r.per != {W{1'b1}}) begin
               s_nxt.per = s_r.per + W'(1);
               if (pwm) begin
                  s_nxt.hi = s_r.hi + W'(1);
               end
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign duty  = s_r.duty;
   assign valid = s_r.valid;

   chk_meter_off_direct: assert property (@(posedge sys_clk) disable iff (rst)
      !en |=> (!valid && duty == '0))
      else $error("duty meter active while disabled");

   chk_hyst_fall_step: assert property (@(posedge sys_clk) disable iff (rst)
      ($past(valid) && valid && duty < $past(duty)) |-> ($past(duty) - duty >= 8'h02))
      else $error("falling duty moved by a single lsb");

endmodule
`default_nettype wire

//--- lsdfc_phase_gen.sv
`timescale 1ns/10ps
`default_nettype none
module lsdfc_phase_gen import lsdfc_pkg::*; #(
   parameter int W = PER_W
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // control
   input  wire logic              en,
   input  wire logic [W-1:0]      period,
   input  wire logic [DUTY_W-1:0] duty,
   input  wire logic [NCH-1:0]    chan_en,
   // sink drive
   output logic [NCH-1:0]         sink
);

   typedef struct packed {
      logic [W-1:0]   cnt;
      logic [NCH-1:0] sink;
   } lsdfc_phase_s;

   lsdfc_phase_s s_r;
   lsdfc_phase_s s_nxt;

   always_comb begin
      logic [NCH_W-1:0]    used;
      logic [W+DUTY_W-1:0] prod;
      logic [W-1:0]        on_time;
      logic [W-1:0]        delay;
      logic [W-1:0]        offs;
      logic [W:0]          pos;
      used    = lsdfc_popcount(chan_en);
      prod    = (W+DUTY_W)'(duty) * (W+DUTY_W)'(period);
      on_time = prod[W+DUTY_W-1:DUTY_SHIFT];
      delay   = (used == '0) ? period : period / W'(used);
      offs    = '0;
      pos     = '0;
      s_nxt   = s_r;
      s_nxt.cnt = (s_r.cnt >= period - W'(1)) ? '0 : s_r.cnt + W'(1);
      for (int k = 0; k < NCH; k++) begin
         // slot follows rank among used channels, ascending
         offs = W'(lsdfc_popcount(chan_en & NCH'((1 << k) - 1))) * delay;
         pos  = (s_r.cnt >= offs) ? {1'b0, s_r.cnt - offs}
                                  : {1'b0, s_r.cnt} + {1'b0, period} - {1'b0, offs};
         s_nxt.sink[k] = chan_en[k] && (pos < {1'b0, on_time});
      end
      if (!en) begin
         s_nxt = '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sink = s_r.sink;

   chk_phase_idle_dark: assert property (@(posedge sys_clk) disable iff (rst)
      (!en || chan_en == '0) |=> sink == '0)
      else $error("phase sinks on while idle");

endmodule
`default_nettype wire

//--- lsdfc_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module lsdfc_ctrl import lsdfc_pkg::*; #(
   parameter int OC_PERSIST_CYCLES = OC_PERSIST_SW
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   // enable and mode pins
   input  wire logic              enable,
   input  wire logic              dim_freq_mode_select_pin,
   input  wire logic [RES_W-1:0]  dimming_frequency_resistor,
   // brightness input
   input  wire logic              brightness_pwm_input,
   // string sensing
   input  wire logic [NCH-1:0]    string_current_feedback,
   input  wire logic [NCH-1:0]    string_overvoltage,
   // boost sensing
   input  wire lsdfc_sense_s      sense,
   // outputs
   output logic [NCH-1:0]         sink_on,
   output logic [NCH-1:0]         chan_active,
   output lsdfc_boost_s           boost,
   output logic [DUTY_W-1:0]      duty_value,
   output logic                   fault_latched
);

   localparam int OC_W = $clog2(OC_PERSIST_CYCLES + 1);

   typedef struct packed {
      lsdfc_state_e     st;
      logic [NCH-1:0]   chan_en;
      logic [NCH-1:0]   seen;
      logic [CHK_W-1:0] chk_cnt;
      logic [OC_W-1:0]  oc_cnt;
      logic             cyc_oc;
      logic             sw_allow;
      logic             clamp;
      logic [NCH-1:0]   sink;
   } lsdfc_top_s;

   lsdfc_top_s s_r;
   lsdfc_top_s s_nxt;

   logic              direct_mode;
   logic              run_phase;
   logic              meter_valid;
   logic [DUTY_W-1:0] meter_duty;
   logic [NCH-1:0]    phase_sink;
   logic [PER_W-1:0]  dim_period;
   logic              sig_ok;
   logic              powered;

   assign direct_mode = dim_freq_mode_select_pin;
   assign run_phase   = (s_r.st == ST_RUN) && !direct_mode;
   assign dim_period  = lsdfc_period_cycles(dimming_frequency_resistor);
   // direct mode needs no measurement: a floating low input keeps sinks dark
   assign sig_ok      = direct_mode ? 1'b1 : meter_valid;
   assign powered     = (s_r.st == ST_RUN) || (s_r.st == ST_CHECK);

   lsdfc_duty_meter #(
      .W (MEAS_W)
   ) u_meter (
      .sys_clk (sys_clk),
      .rst     (rst),
      .en      (run_phase),
      .pwm     (brightness_pwm_input),
      .duty    (meter_duty),
      .valid   (meter_valid)
   );

   lsdfc_phase_gen #(
      .W (PER_W)
   ) u_phase (
      .sys_clk (sys_clk),
      .rst     (rst),
      .en      (run_phase && meter_valid),
      .period  (dim_period),
      .duty    (meter_duty),
      .chan_en (s_r.chan_en),
      .sink    (phase_sink)
   );

   always_comb begin
      s_nxt = s_r;
      unique case (s_r.st)
         ST_OFF: begin
            s_nxt.chan_en = '0;
            s_nxt.seen    = '0;
            s_nxt.chk_cnt = '0;
            s_nxt.oc_cnt  = '0;
            s_nxt.cyc_oc  = 1'b0;
            if (enable) begin
               s_nxt.st = ST_CHECK;
            end
         end
         ST_CHECK: begin
            s_nxt.seen    = s_r.seen | string_current_feedback;
            s_nxt.chk_cnt = s_r.chk_cnt + CHK_W'(1);
            if (s_r.chk_cnt == CHK_W'(CHECK_CYC - 1)) begin
               s_nxt.chan_en = s_nxt.seen;
               s_nxt.st      = (s_nxt.seen == '0) ? ST_LATCH : ST_RUN;
            end
         end
         ST_RUN: begin
            // only a sink that is driven can prove its string open
            s_nxt.chan_en = s_r.chan_en & ~string_overvoltage
                          & ~(s_r.sink & ~string_current_feedback);
            if (sense.cycle_start) begin
               s_nxt.cyc_oc = sense.inductor_oc;
               if (s_r.cyc_oc) begin
                  s_nxt.oc_cnt = s_r.oc_cnt + OC_W'(1);
               end else begin
                  s_nxt.oc_cnt = '0;
               end
            end else begin
               s_nxt.cyc_oc = s_r.cyc_oc | sense.inductor_oc;
            end
            if (s_nxt.chan_en == '0) begin
               s_nxt.st = ST_LATCH;
            end
            if (sense.out_short) begin
               s_nxt.st = ST_LATCH;
            end
            if (sense.over_temp) begin
               s_nxt.st = ST_LATCH;
            end
            if (s_nxt.oc_cnt >= OC_W'(OC_PERSIST_CYCLES)) begin
               s_nxt.st = ST_LATCH;
            end
         end
         ST_LATCH: begin
            s_nxt.chan_en = '0;
         end
      endcase
      if (!enable) begin
         s_nxt.st      = ST_OFF;
         s_nxt.chan_en = '0;
      end
      // the limit wins over a cycle start arriving in the same clock
      if (sense.inductor_oc) begin
         s_nxt.sw_allow = 1'b0;
      end else if (sense.cycle_start) begin
         s_nxt.sw_allow = 1'b1;
      end
      if ((s_nxt.st != ST_RUN) && (s_nxt.st != ST_CHECK)) begin
         s_nxt.sw_allow = 1'b0;
      end
      s_nxt.clamp = sense.clamp_over && ((s_nxt.st == ST_RUN) || (s_nxt.st == ST_CHECK));
      s_nxt.sink = '0;
      if (s_nxt.st == ST_CHECK) begin
         s_nxt.sink = '1;
      end else if ((s_r.st == ST_RUN) && (s_nxt.st == ST_RUN) && sig_ok) begin
         if (direct_mode) begin
            s_nxt.sink = s_nxt.chan_en & {NCH{brightness_pwm_input}};
         end else begin
            s_nxt.sink = s_nxt.chan_en & phase_sink;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sink_on             = s_r.sink;
   assign chan_active         = s_r.chan_en;
   assign boost.enable        = powered;
   assign boost.switch_allow  = s_r.sw_allow;
   assign boost.clamp         = s_r.clamp;
   assign duty_value          = meter_duty;
   assign fault_latched       = (s_r.st == ST_LATCH);

   chk_enable_low_off: assert property (@(posedge sys_clk) disable iff (rst)
      !enable |=> (sink_on == '0 && !boost.enable && chan_active == '0))
      else $error("device active after enable low");

   chk_latch_holds: assert property (@(posedge sys_clk) disable iff (rst)
      (fault_latched && enable) |=> (fault_latched && sink_on == '0 && !boost.switch_allow))
      else $error("latched fault released without enable toggle");

   chk_chan_no_revive: assert property (@(posedge sys_clk) disable iff (rst)
      ($past(s_r.st) == ST_RUN && s_r.st == ST_RUN) |-> ((chan_active & ~$past(chan_active)) == '0))
      else $error("deactivated channel came back");

   chk_ov_chan_off: assert property (@(posedge sys_clk) disable iff (rst)
      (s_r.st == ST_RUN && enable && (string_overvoltage & chan_active) != '0)
         |=> ((chan_active | sink_on) & $past(string_overvoltage)) == '0)
      else $error("overvoltage channel stayed active");

   chk_open_chan_drop: assert property (@(posedge sys_clk) disable iff (rst)
      (s_r.st == ST_RUN && enable && (sink_on & ~string_current_feedback) != '0)
         |=> (chan_active & $past(sink_on & ~string_current_feedback)) == '0)
      else $error("open string not removed");

   chk_fault_shutdown: assert property (@(posedge sys_clk) disable iff (rst)
      (s_r.st == ST_RUN && enable && (sense.out_short || sense.over_temp))
         |=> (fault_latched && sink_on == '0) ##1 !boost.enable)
      else $error("short or thermal fault did not shut down");

   chk_all_open_latch: assert property (@(posedge sys_clk) disable iff (rst)
      (s_r.st == ST_RUN && enable
         && (chan_active & ~string_overvoltage & ~(sink_on & ~string_current_feedback)) == '0)
         |=> fault_latched)
      else $error("running with no strings");

   chk_cycle_limit: assert property (@(posedge sys_clk) disable iff (rst)
      sense.inductor_oc |=> !boost.switch_allow)
      else $error("switch allowed after current limit");

   chk_no_signal_dark: assert property (@(posedge sys_clk) disable iff (rst)
      (s_r.st == ST_RUN && !sig_ok) |=> sink_on == '0)
      else $error("sinks driven before a signal was detected");

   chk_direct_follow: assert property (@(posedge sys_clk) disable iff (rst)
      (s_r.st == ST_RUN && enable && direct_mode && $past(s_r.st) == ST_RUN)
         |=> sink_on == (($past(brightness_pwm_input) && !fault_latched) ? chan_active : '0))
      else $error("direct mode sinks do not follow input");

   chk_clamp_follow: assert property (@(posedge sys_clk) disable iff (rst)
      (s_r.st == ST_RUN && enable && sense.clamp_over) |=> boost.clamp)
      else $error("clamp not applied");

   chk_check_time: assert property (@(posedge sys_clk) disable iff (rst)
      (s_r.st == ST_CHECK && s_r.chk_cnt == '0 && enable) |-> ##1 s_r.st == ST_CHECK)
      else $error("startup check cut short");

   chk_check_all_on: assert property (@(posedge sys_clk) disable iff (rst)
      s_r.st == ST_CHECK
         |-> (sink_on == '1 && boost.enable))
      else $error("sinks not all on during startup check");

   chk_check_result: assert property (@(posedge sys_clk) disable iff (rst)
      (s_r.st == ST_CHECK && enable && s_r.chk_cnt == CHK_W'(CHECK_CYC - 1))
         |=> chan_active == $past(s_r.seen | string_current_feedback))
      else $error("startup check kept a channel without current");

   // quiet states: nothing may drive a sink or the power switch
   chk_off_all_dark: assert property (@(posedge sys_clk) disable iff (rst)
      s_r.st == ST_OFF
         |-> (sink_on == '0 && chan_active == '0 && !boost.switch_allow))
      else $error("shutdown state left an output active");

   chk_unpowered_idle: assert property (@(posedge sys_clk) disable iff (rst)
      !boost.enable
         |-> (!boost.switch_allow && !boost.clamp))
      else $error("boost controls active while converter off");

   chk_latch_all_dark: assert property (@(posedge sys_clk) disable iff (rst)
      fault_latched
         |-> (sink_on == '0 && !boost.enable && !boost.switch_allow))
      else $error("latched fault left an output active");

   chk_run_has_chan: assert property (@(posedge sys_clk) disable iff (rst)
      s_r.st == ST_RUN
         |-> chan_active != '0)
      else $error("running with no used channel");

   chk_sink_used_only: assert property (@(posedge sys_clk) disable iff (rst)
      s_r.st != ST_CHECK
         |-> (sink_on & ~chan_active) == '0)
      else $error("sink driven on an unused channel");

   chk_meter_idle_direct: assert property (@(posedge sys_clk) disable iff (rst)
      (direct_mode || s_r.st != ST_RUN)
         |=> (!meter_valid && duty_value == '0))
      else $error("duty meter running outside phase mode");

   chk_sw_rise_start: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(boost.switch_allow)
         |-> $past(sense.cycle_start && !sense.inductor_oc))
      else $error("switch allowed without a clean cycle start");

   chk_oc_persist_latch: assert property (@(posedge sys_clk) disable iff (rst)
      (s_r.st == ST_RUN && enable && sense.cycle_start && s_r.cyc_oc
         && s_r.oc_cnt == OC_W'(OC_PERSIST_CYCLES - 1)) |=> fault_latched)
      else $error("persistent overcurrent did not latch");

   chk_temp_latch: assert property (@(posedge sys_clk) disable iff (rst)
      (s_r.st == ST_RUN && enable && sense.over_temp)
         |=> fault_latched)
      else $error("thermal fault did not latch");

   chk_restart_toggle: assert property (@(posedge sys_clk) disable iff (rst)
      (s_r.st == ST_OFF && enable)
         |=> (boost.enable && sink_on == '1))
      else $error("enable rise did not restart the check");

   chk_clamp_needs_over: assert property (@(posedge sys_clk) disable iff (rst)
      boost.clamp
         |-> $past(sense.clamp_over))
      else $error("clamp applied without clamp input");

   cov_phase_run: cover property (@(posedge sys_clk) disable iff (rst)
      run_phase && meter_valid && sink_on != '0);

   cov_direct_run: cover property (@(posedge sys_clk) disable iff (rst)
      s_r.st == ST_RUN && direct_mode && sink_on != '0);

   cov_string_open: cover property (@(posedge sys_clk) disable iff (rst)
      s_r.st == ST_RUN ##1 (chan_active != $past(chan_active) && !fault_latched));

   cov_latched: cover property (@(posedge sys_clk) disable iff (rst)
      s_r.st == ST_RUN ##1 fault_latched);

   cov_check_done: cover property (@(posedge sys_clk) disable iff (rst)
      s_r.st == ST_CHECK ##1 s_r.st == ST_RUN);

endmodule
`default_nettype wire

//--- lsdfc_host_pwm.sv
`timescale 1ns/10ps
`default_nettype none
module lsdfc_host_pwm import lsdfc_pkg::*; (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // waveform set by the bench
   input  wire logic        run,
   input  wire logic [15:0] period,
   input  wire logic [15:0] high,
   // brightness line
   output logic             pwm
);
   logic [15:0] cnt_r;
   logic [15:0] high_r;

   // new duty lands only at a period start, so the frequency never wobbles
   always_ff @(posedge sys_clk) begin
      if (rst || !run) begin
         cnt_r  <= 16'h0000;
         high_r <= high;
         pwm    <= 1'b0;
      end else begin
         cnt_r <= (cnt_r == period - 16'h0001) ? 16'h0000 : cnt_r + 16'h0001;
         if (cnt_r == 16'h0000) high_r <= high;
         pwm <= (cnt_r == 16'h0000) ? (high != 16'h0000) : (cnt_r < high_r);
      end
   end
endmodule
`default_nettype wire

//--- lsdfc_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module lsdfc_ctrl_tb_top import lsdfc_pkg::*;;
   // 9090 ohm on the mode pin gives 500 clock cycles per dimming period
   localparam int PER  = 500;
   localparam int HPER = 200;
   logic              sys_clk  = 1'b0;
   logic              rst      = 1'b1;
   logic              enable   = 1'b0;
   logic              mode_pin = 1'b0;
   logic [RES_W-1:0]  res      = RES_W'(9090);
   logic [NCH-1:0]    fb       = 6'h00;
   logic [NCH-1:0]    ovr      = 6'h00;
   lsdfc_sense_s      sense    = '0;
   logic              host_run = 1'b0;
   logic [15:0]       high     = 16'h0064;
   logic              dir_pwm  = 1'b0;
   logic              host_pwm;
   logic              pwm_in;
   logic [NCH-1:0]    sink_on;
   logic [NCH-1:0]    chan_active;
   lsdfc_boost_s      boost;
   logic [DUTY_W-1:0] duty_value;
   logic              fault_latched;
   int                error_cnt = 0;
   int                checks    = 0;
   int                stored    = 0;
   int                exp_act   = 0;
   int                hs[4]     = '{100, 101, 100, 99};
   logic              last;

   assign pwm_in = mode_pin ? dir_pwm : host_pwm;
   always #50 sys_clk = ~sys_clk;

   lsdfc_ctrl #(.OC_PERSIST_CYCLES(4)) uut (
      .sys_clk(sys_clk), .rst(rst), .enable(enable),
      .dim_freq_mode_select_pin(mode_pin), .dimming_frequency_resistor(res),
      .brightness_pwm_input(pwm_in), .string_current_feedback(fb),
      .string_overvoltage(ovr), .sense(sense), .sink_on(sink_on),
      .chan_active(chan_active), .boost(boost), .duty_value(duty_value),
      .fault_latched(fault_latched));

   lsdfc_host_pwm host (
      .sys_clk(sys_clk), .rst(rst), .run(host_run), .period(16'(HPER)),
      .high(high), .pwm(host_pwm));

   task automatic clk(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wrap_up;
      if (error_cnt == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   function automatic int model_duty(input int old, input int h);
      int nd;
      nd = h * 256 / HPER;
      if (nd > 255) nd = 255;
      return (nd > old || nd + 1 < old) ? nd : old;
   endfunction

   // enable toggle, then the startup channel check
   task automatic restart(input logic [NCH-1:0] fbv);
      clk(1);
      enable <= 1'b0;
      clk(1);
      #1;
      cmp({boost.enable, sink_on}, 7'h00);
      clk(1);
      fb <= fbv;
      enable <= 1'b1;
      clk(1);
      #1;
      cmp({boost.enable, sink_on}, 7'h7f);
      clk(1000);
      #1;
      exp_act = int'(fbv);
      cmp(chan_active, exp_act);
   endtask

   // on-time over one period and rise offsets between used channels
   task automatic measure(input int duty);
      integer rise[NCH];
      integer cnt[NCH];
      logic [NCH-1:0] prev;
      int first;
      int n;
      int slot;
      first = -1;
      n = 0;
      slot = 0;
      prev = 6'h3f;
      for (int k = 0; k < NCH; k++) begin
         rise[k] = -1;
         cnt[k] = 0;
         n += exp_act[k];
      end
      for (int i = 0; i < 2 * PER; i++) begin
         clk(1);
         #1;
         for (int k = 0; k < NCH; k++) begin
            if (sink_on[k] === 1'b1 && prev[k] === 1'b0 && rise[k] < 0) rise[k] = i;
            if (i < PER && sink_on[k] === 1'b1) cnt[k] = cnt[k] + 1;
         end
         prev = sink_on;
      end
      for (int k = 0; k < NCH; k++) begin
         if (exp_act[k]) begin
            if (first < 0) first = k;
            cmp(cnt[k], duty * PER / 256);
            cmp(((rise[k] - rise[first]) % PER + PER) % PER, slot * (PER / n));
            slot++;
         end else begin
            cmp(cnt[k], 0);
         end
      end
   endtask

   initial begin
      void'($urandom(34907));
      clk(5);
      rst <= 1'b0;
      #1;
      cmp({fault_latched, boost, duty_value, chan_active, sink_on}, 32'h0);
      restart(6'h2d);
      clk(300);
      #1;
      cmp(sink_on, 6'h00);
      clk(1);
      host_run <= 1'b1;
      for (int j = 0; j < 4; j++) begin
         clk(1);
         high <= 16'(hs[j]);
         clk(3 * HPER);
         #1;
         stored = model_duty(stored, hs[j]);
         cmp(duty_value, stored);
         if (j == 0) measure(stored);
      end
      clk(1);
      ovr <= 6'h04;
      sense.cycle_start <= 1'b1;
      clk(1);
      #1;
      exp_act = 'h29;
      cmp({boost.switch_allow, chan_active}, 7'h40 | exp_act);
      clk(1);
      ovr <= 6'h00;
      sense.cycle_start <= 1'b0;
      sense.clamp_over <= 1'b1;
      sense.inductor_oc <= 1'b1;
      clk(1);
      #1;
      cmp({boost.clamp, boost.switch_allow}, 2'b10);
      clk(1);
      sense.clamp_over <= 1'b0;
      sense.inductor_oc <= 1'b0;
      clk(3);
      #1;
      cmp({boost.clamp, boost.switch_allow, chan_active}, 'h29);
      clk(1);
      sense.cycle_start <= 1'b1;
      clk(1);
      sense.cycle_start <= 1'b0;
      #1;
      cmp(boost.switch_allow, 1'b1);
      clk(1);
      fb <= 6'h2c;
      for (int i = 0; i < 2 * PER && chan_active[0] !== 1'b0; i++) begin
         clk(1);
         #1;
      end
      exp_act = 'h28;
      cmp({fault_latched, chan_active}, exp_act);
      // let the new slot plan settle through the sink pipeline
      clk(2);
      measure(stored);
      restart(6'h2d);
      clk(1);
      mode_pin <= 1'b1;
      host_run <= 1'b0;
      clk(3);
      for (int i = 0; i < 200; i++) begin
         clk(1);
         last = dir_pwm;
         dir_pwm <= 1'($urandom);
         #1;
         cmp(sink_on, NCH'(exp_act) & {NCH{last}});
      end
      clk(1);
      sense.inductor_oc <= 1'b1;
      repeat (5) begin
         clk(2);
         sense.cycle_start <= 1'b1;
         clk(1);
         sense.cycle_start <= 1'b0;
      end
      clk(1);
      #1;
      cmp({fault_latched, sink_on}, 7'h40);
      clk(1);
      sense.inductor_oc <= 1'b0;
      for (int f = 0; f < 2; f++) begin
         restart(6'h2d);
         clk(1);
         dir_pwm <= 1'b1;
         if (f == 0) sense.out_short <= 1'b1;
         else sense.over_temp <= 1'b1;
         clk(1);
         #1;
         cmp({fault_latched, sink_on}, 7'h40);
         clk(1);
         sense.out_short <= 1'b0;
         sense.over_temp <= 1'b0;
         clk(5);
         #1;
         cmp(fault_latched, 1'b1);
      end
      restart(6'h2d);
      clk(1);
      fb <= 6'h00;
      clk(1);
      #1;
      cmp({fault_latched, chan_active}, 7'h40);
      restart(6'h00);
      cmp(fault_latched, 1'b1);
      wrap_up();
   end

   // the full run needs some 11000 cycles; well beyond that means a hang
   initial begin
      clk(40000);
      error_cnt++;
      wrap_up();
   end
endmodule
`default_nettype wire
